// >>> design/sfcr_pkg.sv
package sfcr_pkg;
  localparam int ADDR_W = 24;
  localparam int CLK_NS = 5;
  localparam int WREG_NS = 1000;
  localparam int PE_NS = 20000;
  localparam int WREG_CYC = (WREG_NS + CLK_NS - 1) / CLK_NS;
  localparam int PE_CYC = (PE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  localparam int SR_SRWD = 7;
  localparam int SR_BP3 = 6;
  localparam int SR_TB = 5;
  localparam int SR_BP_HI = 4;
  localparam int SR_BP_LO = 2;
  localparam int SR_WEL = 1;
  localparam int SR_WIP = 0;
  localparam logic [7:0] SR_NV_MASK = 8'hFC;
  localparam logic [7:0] NV_STATUS_RST = 8'h00;
  localparam int NV_DUM_HI = 15;
  localparam int NV_DUM_LO = 12;
  localparam int NV_XIP_HI = 11;
  localparam int NV_XIP_LO = 9;
  localparam int NV_DRV_HI = 8;
  localparam int NV_DRV_LO = 6;
  localparam int NV_QUAD = 3;
  localparam int NV_DUAL = 2;
  localparam int NV_LOCK = 0;
  localparam logic [15:0] NV_CONFIG_RST = 16'hFFFF;
  localparam int VC_DUM_HI = 7;
  localparam int VC_DUM_LO = 4;
  localparam int VC_XIP = 3;
  localparam int VC_WRAP_HI = 1;
  localparam int VC_WRAP_LO = 0;
  localparam logic [7:0] VCR_RST = 8'hFB;
  localparam logic [3:0] DUMMY_ALT = 4'h0;
  localparam logic [3:0] DUMMY_DEF = 4'hF;
  localparam logic [2:0] XIP_FAST = 3'h0;
  localparam logic [2:0] XIP_QIO = 3'h4;
  localparam logic [2:0] XIP_OFF = 3'h7;
  localparam logic [1:0] WRAP_SEQ = 2'h3;

  typedef enum logic [2:0] {
    CMD_WREN = 3'b000,
    CMD_WRDI = 3'b001,
    CMD_WRSR = 3'b010,
    CMD_WRNVCR = 3'b011,
    CMD_WRVCR = 3'b100,
    CMD_PROG = 3'b101,
    CMD_ERASE = 3'b110,
    CMD_BULK = 3'b111
  } sfcr_cmd_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } sfcr_state_t;

  typedef struct packed {
    sfcr_cmd_t op;
    logic [15:0] data;
    logic [ADDR_W-1:0] addr;
  } sfcr_req_t;

  typedef struct packed {
    logic [3:0] dummy;
    logic [2:0] xip_mode;
    logic [2:0] drive;
    logic quad;
    logic dual;
    logic [1:0] wrap;
  } sfcr_work_t;

  typedef struct packed {
    logic [7:0] status;
    logic [15:0] boot_configuration;
    logic [7:0] vcr;
  } sfcr_view_t;
endpackage : sfcr_pkg

// >>> design/sfcr_regs.sv
// Operation
// - Boot loads working config from nonvolatile config
// - Volatile config write updates working config immediately
// - Power-on reset discards volatile config changes
// - Lock bit plus low protect pin blocks status writes
// - Status lock bit is one-time programmable
// - Bit five picks top or bottom region
// - Bulk erase only with all protect bits clear
// - Write latch clear at power-up, gates writes
// - Bit zero shows write cycle in progress
// - Reset clears all volatile status bits
// - Status readable, writable bits updated on write
// - Dummy count codes zero and fifteen identical
// - Config bits select boot execute-in-place mode
// - Boot protocol quad or dual, quad wins
// - Cleared config lock ignores later config writes
`timescale 1ns/10ps
module sfcr_regs
  import sfcr_pkg::*;
#(
  parameter int SEC_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wp_n_i,
  input wire logic [7:0] nv_status_i,
  input wire logic [15:0] nv_config_i,
  input wire logic sclk_i,
  input wire logic req_valid_i,
  input wire sfcr_req_t req_i,
  output logic req_ready_o,
  output sfcr_view_t view_o,
  output sfcr_work_t work_o,
  output logic busy_o,
  output logic op_go_o,
  output sfcr_cmd_t op_kind_o,
  output logic [ADDR_W-1:0] op_addr_o,
  output logic nv_wr_o,
  output logic [7:0] nv_status_o,
  output logic [15:0] nv_config_o
);

  if (SEC_W < 1 || SEC_W > ADDR_W) begin : g_bad_sec_w
    $error("SEC_W must lie between 1 and ADDR_W");
  end

  function automatic logic [3:0] dummy_fn(input logic [3:0] c);
    dummy_fn = (c == DUMMY_ALT) ? DUMMY_DEF : c;
  endfunction : dummy_fn

  function automatic sfcr_work_t boot_fn(input logic [15:0] nv);
    logic [2:0] x;
    x = nv[NV_XIP_HI:NV_XIP_LO];
    boot_fn.dummy = dummy_fn(nv[NV_DUM_HI:NV_DUM_LO]);
    // Reserved codes fall back to disabled
    boot_fn.xip_mode = (x > XIP_QIO) ? XIP_OFF : x;
    boot_fn.drive = nv[NV_DRV_HI:NV_DRV_LO];
    boot_fn.quad = ~nv[NV_QUAD];
    boot_fn.dual = ~nv[NV_DUAL] & nv[NV_QUAD];
    boot_fn.wrap = WRAP_SEQ;
  endfunction : boot_fn

  function automatic logic [7:0] boot_vcr_fn(input logic [15:0] nv);
    boot_vcr_fn = {dummy_fn(nv[NV_DUM_HI:NV_DUM_LO]),
                   nv[NV_XIP_HI:NV_XIP_LO] == XIP_OFF, 1'h0, WRAP_SEQ};
  endfunction : boot_vcr_fn

  // Region size doubles with each step of the protect code
  function automatic logic prot_fn(input logic [3:0] bp, input logic tb,
                                   input logic [SEC_W-1:0] sec);
    logic [SEC_W-1:0] hi;
    logic [SEC_W-1:0] top;
    hi = sec >> (bp - 4'h1);
    top = {SEC_W{1'h1}} >> (bp - 4'h1);
    if (bp == 4'h0) begin
      prot_fn = 1'h0;
    end else if (32'(bp) > SEC_W) begin
      prot_fn = 1'h1;
    end else begin
      prot_fn = tb ? (hi == '0) : (hi == top);
    end
  endfunction : prot_fn

  // Link-side reset, taken over from the core domain
  logic lrst_s1_r;
  logic lrst_r;
  always_ff @(posedge sclk_i) begin
    lrst_s1_r <= rst_i;
    lrst_r <= lrst_s1_r;
  end

  logic lk_tgl_r;
  logic ack_r;
  logic ack_s1_r;
  logic ack_s2_r;
  sfcr_req_t lk_req_r;
  wire lk_take = req_valid_i & req_ready_o;

  // Request word is held until the core acknowledges it
  always_ff @(posedge sclk_i) begin
    if (lrst_r) begin
      lk_tgl_r <= 1'h0;
      lk_req_r <= '0;
      req_ready_o <= 1'h0;
      ack_s1_r <= 1'h0;
      ack_s2_r <= 1'h0;
    end else begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
      if (lk_take) begin
        lk_req_r <= req_i;
        lk_tgl_r <= ~lk_tgl_r;
      end
      req_ready_o <= ~lk_take & (lk_tgl_r == ack_s2_r);
    end
  end

  logic pub_tgl_r;
  sfcr_view_t pub_r;
  logic v_s1_r;
  logic v_s2_r;
  logic v_s3_r;
  logic lk_vack_r;

  // Register view for read commands, copied on each new snapshot
  always_ff @(posedge sclk_i) begin
    if (lrst_r) begin
      v_s1_r <= 1'h0;
      v_s2_r <= 1'h0;
      v_s3_r <= 1'h0;
      lk_vack_r <= 1'h0;
      view_o <= '0;
    end else begin
      v_s1_r <= pub_tgl_r;
      v_s2_r <= v_s1_r;
      v_s3_r <= v_s2_r;
      lk_vack_r <= v_s3_r;
      if (v_s2_r ^ v_s3_r) begin
        view_o <= pub_r;
      end
    end
  end

  sfcr_state_t st_r;
  sfcr_state_t st_nxt;
  logic rq_s1_r;
  logic rq_s2_r;
  logic wp_s1_r;
  logic wp_s2_r;
  logic vk_s1_r;
  logic vk_s2_r;
  logic wel_r;
  logic wel_nxt;
  logic [7:0] nvsr_r;
  logic [7:0] vcr_r;
  logic [CNT_W-1:0] cnt_r;

  wire new_req = rq_s2_r ^ ack_r;
  wire take = new_req & (st_r == ST_IDLE);
  sfcr_cmd_t op;
  assign op = lk_req_r.op;
  wire [15:0] wd = lk_req_r.data;
  wire [3:0] bp = {nvsr_r[SR_BP3], nvsr_r[SR_BP_HI:SR_BP_LO]};
  wire wp_lock = nvsr_r[SR_SRWD] & ~wp_s2_r;
  wire hit = prot_fn(bp, nvsr_r[SR_TB],
                     lk_req_r.addr[ADDR_W-1 -: SEC_W]);
  wire pe_op = (op == CMD_PROG) | (op == CMD_ERASE);
  wire do_wren = take & (op == CMD_WREN);
  wire do_wrdi = take & (op == CMD_WRDI);
  wire do_wrsr = take & (op == CMD_WRSR) & wel_r & ~wp_lock;
  wire do_boot_configuration = take & (op == CMD_WRNVCR) & wel_r
                 & nv_config_o[NV_LOCK];
  wire do_vcr = take & (op == CMD_WRVCR) & wel_r;
  wire do_pe = take & wel_r & ((pe_op & ~hit)
               | ((op == CMD_BULK) & (bp == 4'h0)));
  wire reg_go = do_wrsr | do_boot_configuration;
  wire go_busy = reg_go | do_pe;
  wire done = (st_r == ST_BUSY) & (cnt_r == '0);
  wire [7:0] sr_wr = {nvsr_r[SR_SRWD] | wd[SR_SRWD],
                      wd[SR_BP3:SR_BP_LO], 2'h0};
  wire [7:0] status = {nvsr_r[SR_SRWD:SR_BP_LO], wel_r, busy_o};
  sfcr_view_t view_now;
  assign view_now = '{status: status, boot_configuration: nv_config_o, vcr: vcr_r};
  wire pub_free = (vk_s2_r == pub_tgl_r) & (view_now != pub_r);
  wire [CNT_W-1:0] cnt_load = do_pe ? CNT_W'(PE_CYC - 1)
                                    : CNT_W'(WREG_CYC - 1);

  always_comb begin
    wel_nxt = wel_r;
    if (do_wren) begin
      wel_nxt = 1'h1;
    end else if (do_wrdi | do_vcr | done) begin
      wel_nxt = 1'h0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_BOOT: st_nxt = ST_IDLE;
      ST_IDLE: st_nxt = go_busy ? ST_BUSY : ST_IDLE;
      ST_BUSY: st_nxt = done ? ST_IDLE : ST_BUSY;
      default: st_nxt = ST_BOOT;
    endcase
  end

  // Synchronisers; a request stays pending until ack_r catches up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rq_s1_r <= 1'h0;
      rq_s2_r <= 1'h0;
      wp_s1_r <= 1'h0;
      wp_s2_r <= 1'h0;
      vk_s1_r <= 1'h0;
      vk_s2_r <= 1'h0;
      ack_r <= 1'h0;
      pub_tgl_r <= 1'h0;
      pub_r <= '0;
    end else if (ce_i) begin
      rq_s1_r <= lk_tgl_r;
      rq_s2_r <= rq_s1_r;
      wp_s1_r <= wp_n_i;
      wp_s2_r <= wp_s1_r;
      vk_s1_r <= lk_vack_r;
      vk_s2_r <= vk_s1_r;
      // Requests wait out boot; when busy they are acked and dropped
      if (new_req & (st_r != ST_BOOT)) begin
        ack_r <= rq_s2_r;
      end
      if (pub_free) begin
        pub_r <= view_now;
        pub_tgl_r <= ~pub_tgl_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_BOOT;
      busy_o <= 1'h0;
      wel_r <= 1'h0;
      cnt_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      busy_o <= (st_nxt == ST_BUSY);
      wel_r <= wel_nxt;
      if (go_busy) begin
        cnt_r <= cnt_load;
      end else if (st_r == ST_BUSY) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

  // Nonvolatile copies take reset defaults, then load from the array at boot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvsr_r <= NV_STATUS_RST;
      nv_config_o <= NV_CONFIG_RST;
      vcr_r <= VCR_RST;
      work_o <= boot_fn(NV_CONFIG_RST);
      nv_wr_o <= 1'h0;
    end else if (ce_i) begin
      nv_wr_o <= reg_go;
      if (st_r == ST_BOOT) begin
        nvsr_r <= nv_status_i & SR_NV_MASK;
        nv_config_o <= nv_config_i;
        work_o <= boot_fn(nv_config_i);
        vcr_r <= boot_vcr_fn(nv_config_i);
      end else if (do_wrsr) begin
        nvsr_r <= sr_wr;
      end else if (do_boot_configuration) begin
        nv_config_o <= wd;
      end else if (do_vcr) begin
        vcr_r <= {wd[VC_DUM_HI:VC_XIP], 1'h0,
                  wd[VC_WRAP_HI:VC_WRAP_LO]};
        work_o.dummy <= dummy_fn(wd[VC_DUM_HI:VC_DUM_LO]);
        work_o.xip_mode <= wd[VC_XIP] ? XIP_OFF : XIP_FAST;
        work_o.wrap <= wd[VC_WRAP_HI:VC_WRAP_LO];
      end
    end
  end

  assign nv_status_o = nvsr_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_go_o <= 1'h0;
      op_kind_o <= CMD_WREN;
      op_addr_o <= '0;
    end else if (ce_i) begin
      op_go_o <= do_pe;
      if (do_pe) begin
        op_kind_o <= op;
        op_addr_o <= lk_req_r.addr;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i | ~ce_i);
  sequence s_reg_start;
    ce_i && reg_go;
  endsequence
  sequence s_busy_run;
    (busy_o && !op_go_o) [*8];
  endsequence

  a_boot_load: assert property (
    st_r == ST_BOOT |=> work_o == boot_fn($past(nv_config_i)))
    else $error("working config not loaded at boot");

  a_vcr_apply: assert property (
    do_vcr |=> work_o.dummy == dummy_fn($past(wd[VC_DUM_HI:VC_DUM_LO]))
               && work_o.wrap == $past(wd[VC_WRAP_HI:VC_WRAP_LO]) && !wel_r)
    else $error("volatile config not applied");

  a_wp_lock: assert property (
    take && op == CMD_WRSR && wp_lock
      |=> $stable(nvsr_r) && !busy_o && !nv_wr_o)
    else $error("status written while protect pin locked");

  a_lock_otp: assert property (
    nvsr_r[SR_SRWD] && st_r != ST_BOOT |=> nvsr_r[SR_SRWD])
    else $error("status lock bit cleared");

  a_prot_refuse: assert property (
    take && pe_op && hit |=> !op_go_o && !busy_o)
    else $error("write into protected region accepted");

  a_bulk_guard: assert property (
    take && op == CMD_BULK && bp != 4'h0 |=> !op_go_o && !busy_o)
    else $error("bulk erase with protect bits set");

  a_wel_gate: assert property (
    take && !wel_r |=> !busy_o && !op_go_o && !nv_wr_o)
    else $error("write ran without write latch");

  a_wip_busy: assert property (
    s_reg_start |=> nv_wr_o ##0 s_busy_run ##1 busy_o)
    else $error("busy bit not held during register write");

  a_wel_done: assert property (
    $fell(busy_o) |-> !wel_r && st_r == ST_IDLE)
    else $error("write latch not cleared at completion");

  a_reset_clear: assert property (
    $fell(rst_i) |-> !wel_r && !busy_o && st_r == ST_BOOT)
    else $error("volatile status not cleared by reset");

  a_nv_lock: assert property (
    take && op == CMD_WRNVCR && !nv_config_o[NV_LOCK]
      |=> $stable(nv_config_o) && !busy_o)
    else $error("locked config register written");

  a_dummy_norm: assert property (
    st_r != ST_BOOT |-> work_o.dummy != DUMMY_ALT)
    else $error("dummy code zero not normalised");

  a_quad_wins: assert property (
    st_r == ST_BOOT && !nv_config_i[NV_QUAD] |=> work_o.quad && !work_o.dual)
    else $error("quad and dual both selected");

endmodule : sfcr_regs

// >>> verif/serial_flash_config_status_regs_tb.sv
`timescale 1ns/10ps
module serial_flash_config_status_regs_tb
  import sfcr_pkg::*;
  ();
  logic clk_i, rst_i, ce_i, wp_n_i, sclk_i, req_valid_i, req_ready_o;
  logic busy_o, op_go_o, nv_wr_o;
  logic [7:0] nv_status_i, nv_status_o;
  logic [15:0] nv_config_i, nv_config_o, cfg, d;
  logic [ADDR_W-1:0] op_addr_o;
  logic [8:0] ev;
  sfcr_req_t req_i;
  sfcr_view_t view_o;
  sfcr_work_t work_o, w;
  sfcr_cmd_t op_kind_o;
  int fail_count = 0, n_checks = 0, bcnt = 0, blen = 0, n_wr = 0, n_go = 0;
  int k;
  logic [15:0] rnd = 16'h0033;

  sfcr_regs #(.SEC_W(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wp_n_i(wp_n_i), .nv_status_i(nv_status_i), .nv_config_i(nv_config_i),
    .sclk_i(sclk_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .view_o(view_o), .work_o(work_o),
    .busy_o(busy_o), .op_go_o(op_go_o), .op_kind_o(op_kind_o),
    .op_addr_o(op_addr_o), .nv_wr_o(nv_wr_o), .nv_status_o(nv_status_o),
    .nv_config_o(nv_config_o));

  sfcr_host host (.ready_i(req_ready_o), .sclk_o(sclk_i),
    .valid_o(req_valid_i), .req_o(req_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Pre-edge values only, so the counts never race the design's updates
  always @(posedge clk_i) begin
    if (busy_o === 1'b1) bcnt++;
    else if (bcnt != 0) begin
      blen = bcnt;
      bcnt = 0;
    end
    if (nv_wr_o === 1'b1) n_wr++;
    if (op_go_o === 1'b1) n_go++;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic sfcr_work_t boot_w(input logic [15:0] c);
    sfcr_work_t x;
    x.dummy = (c[15:12] == 4'h0) ? DUMMY_DEF : c[15:12];
    x.xip_mode = (c[11:9] > XIP_QIO) ? XIP_OFF : c[11:9];
    x.drive = c[8:6];
    x.quad = ~c[3];
    x.dual = c[3] & ~c[2];
    x.wrap = WRAP_SEQ;
    return x;
  endfunction : boot_w

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // Link reset needs sclk edges, so reset stays up longer than two cycles
  task automatic boot(input logic [7:0] s, input logic [15:0] c);
    @(posedge clk_i);
    #1;
    rst_i = 1'b1;
    nv_status_i = s;
    nv_config_i = c;
    repeat (2) @(posedge clk_i);
    host.tick(4);
    @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : boot

  task automatic cmd(input sfcr_cmd_t op, input logic [15:0] dd,
                     input logic [ADDR_W-1:0] a, input bit en);
    int n;
    if (en) host.wr(op, dd, a);
    else host.send(op, dd, a);
    n = 0;
    while (busy_o !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(busy_o, 1'b0);
    host.tick(16);
  endtask : cmd

  task automatic pe(input sfcr_cmd_t op, input logic [ADDR_W-1:0] a,
                    input bit go);
    k = n_go;
    cmd(op, 16'h0000, a, 1'b1);
    chk(n_go - k, go);
    if (go) begin
      chk(op_kind_o, op);
      chk(op_addr_o, a);
      chk(blen, PE_CYC);
    end
  endtask : pe

  task automatic set_wp(input logic v);
    @(posedge clk_i);
    #1;
    wp_n_i = v;
    repeat (4) @(posedge clk_i);
  endtask : set_wp

  initial begin
    ce_i = 1'b1;
    rst_i = 1'b1;
    wp_n_i = 1'b1;
    nv_status_i = 8'h00;
    nv_config_i = 16'hFFFF;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      cfg = {(i == 1) ? 4'h0 : (i == 2) ? 4'hF : rnd[15:12], i[2:0], rnd[8:0]};
      boot({1'b0, rnd[6:0]}, cfg);
      chk(nv_status_o, {1'b0, rnd[6:2], 2'b00});
      chk(work_o, boot_w(cfg));
      chk(busy_o, 1'b0);
      rnd = lfsr(rnd);
      d = {8'h00, rnd[7:3], 1'b0, rnd[1:0]};
      ev = {(d[7:4] == 4'h0) ? DUMMY_DEF : d[7:4],
            d[3] ? XIP_OFF : XIP_FAST, d[1:0]};
      cmd(CMD_WRVCR, d, '0, 1'b1);
      chk({work_o.dummy, work_o.xip_mode, work_o.wrap}, ev);
      chk(view_o.status[1], 1'b0);
      chk(view_o.vcr, d[7:0]);
    end
    boot(8'h03, 16'hFFFF);
    chk(nv_status_o, 8'h00);
    k = n_wr;
    cmd(CMD_WRSR, 16'h001C, '0, 1'b0);
    chk(n_wr - k, 0);
    cmd(CMD_WRSR, 16'h0004, '0, 1'b1);
    chk(nv_status_o, 8'h04);
    chk(view_o.status, 8'h04);
    chk(blen, WREG_CYC);
    chk(n_wr - k, 1);
    rnd = lfsr(rnd);
    pe(CMD_PROG, 24'hFF_0000, 1'b0);
    pe(CMD_PROG, {1'b0, rnd[6:0], rnd}, 1'b1);
    pe(CMD_BULK, 24'h00_0000, 1'b0);
    cmd(CMD_WRSR, 16'h0024, '0, 1'b1);
    pe(CMD_PROG, 24'h00_1234, 1'b0);
    pe(CMD_ERASE, 24'hFF_1234, 1'b1);
    cmd(CMD_WRSR, 16'h0000, '0, 1'b1);
    pe(CMD_BULK, 24'h00_0000, 1'b1);
    cmd(CMD_WRSR, 16'h0080, '0, 1'b1);
    set_wp(1'b0);
    cmd(CMD_WRSR, 16'h0004, '0, 1'b1);
    chk(nv_status_o, 8'h80);
    set_wp(1'b1);
    cmd(CMD_WRSR, 16'h0008, '0, 1'b1);
    chk(nv_status_o, 8'h88);
    cmd(CMD_WRSR, 16'h0000, '0, 1'b1);
    chk(nv_status_o, 8'h80);
    rnd = lfsr(rnd);
    d = {rnd[15:1], 1'b1};
    w = work_o;
    // Clock enable low in mid-cycle must stretch busy by the frozen edges
    fork
      cmd(CMD_WRNVCR, d, '0, 1'b1);
      begin
        wait (busy_o === 1'b1);
        @(posedge clk_i);
        #1;
        ce_i = 1'b0;
        repeat (20) @(posedge clk_i);
        #1;
        ce_i = 1'b1;
      end
    join
    chk(nv_config_o, d);
    chk(view_o.boot_configuration, d);
    chk(blen, WREG_CYC + 20);
    chk(work_o, w);
    cmd(CMD_WRNVCR, 16'h1230, '0, 1'b1);
    cmd(CMD_WRNVCR, 16'hFFFF, '0, 1'b1);
    chk(nv_config_o, 16'h1230);
    chk(host.n_to, 0);
    results();
  end

  // Three array cycles dominate the run, well under this span
  initial begin
    #300000;
    fail_count++;
    results();
  end
endmodule : serial_flash_config_status_regs_tb

// >>> verif/sfcr_host.sv
`timescale 1ns/10ps
module sfcr_host
  import sfcr_pkg::*;
(
  input wire logic ready_i,
  output logic sclk_o,
  output logic valid_o,
  output sfcr_req_t req_o
);
  logic run;
  int n_to = 0;

  // Link clock stands still between frames, phase unrelated to clk_i
  initial begin
    run = 1'b0;
    sclk_o = 1'b0;
    valid_o = 1'b0;
    req_o = '0;
    #1.3;
    forever begin
      #6;
      if (run) sclk_o = ~sclk_o;
    end
  end

  task automatic tick(input int n);
    run = 1'b1;
    repeat (n) @(negedge sclk_o);
    run = 1'b0;
  endtask : tick

  // Ready only moves on a rising edge, so it is looked at on the falling one
  task automatic send(input sfcr_cmd_t op, input logic [15:0] d,
                      input logic [ADDR_W-1:0] a);
    int n;
    run = 1'b1;
    @(posedge sclk_o);
    #1;
    req_o = {op, d, a};
    valid_o = 1'b1;
    n = 0;
    do begin
      @(negedge sclk_o);
      n++;
    end while (ready_i !== 1'b1 && n < 100);
    if (ready_i !== 1'b1) n_to++;
    @(posedge sclk_o);
    #1;
    valid_o = 1'b0;
    req_o = ~req_o;
    n = 0;
    do begin
      @(negedge sclk_o);
      n++;
    end while (ready_i !== 1'b1 && n < 100);
    if (ready_i !== 1'b1) n_to++;
    run = 1'b0;
  endtask : send

  task automatic wr(input sfcr_cmd_t op, input logic [15:0] d,
                    input logic [ADDR_W-1:0] a);
    send(CMD_WREN, 16'h0000, '0);
    send(op, d, a);
  endtask : wr
endmodule : sfcr_host
